/* File: rbac_framer.sv */
/*
 Receive bit framing: aligns received bits into bytes, reports last
 valid bit count, handles collisions, and holds the two registers.
 Assumes a decoder that strobes one bit at a time between frame start
 and frame end pulses, and a consumer that drains the byte FIFO.
 Software writes to the last-bits field are dropped; the decoder owns it.
 The host should trust the collision position only when flagged valid.
*/
// Notes on behaviour
// - Keep bit clear zeroes bits after collision
// - Alignment field sets first bit position
// - Positions past seven wrap into next byte
// - Zero alignment means byte-oriented reception
// - Collision raises integrity error when enabled
// - Last-bits field counts valid final bits
// - Last-bits cleared at start, loaded at end in bit-oriented mode
// - Valid flag only for reportable collision
// - Seven-bit first collision index, eight bytes
// - Position is zero-based across bytes
// - Alignment is added into the position
// - Collision flag clears at receive start
// - Integrity error sets, reception continues
`timescale 1ns/1ps
`include "rbac_regs.svh"
module rbac_framer #(
   parameter int FIFO_DEPTH = `RBAC_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Register access
   input wire rbac_pkg::rbac_req_t req,
   output logic [7:0] rdata,
   // Receive decoder
   input wire logic frameStart,
   input wire logic frameEnd,
   input wire logic bitStrobe,
   input wire rbac_pkg::rbac_bit_t rxBit,
   input wire logic parityErr,
   input wire logic crcErr,
   // Stalls the decoder while a byte is staged for the FIFO
   output logic bitReady,
   // Received bytes
   output logic byteValid,
   input wire logic byteReady,
   output logic [7:0] byteData,
   // Status
   output logic integrityErr,
   output logic collisionSeen,
   output logic bitOriented
);
   rbac_pkg::rbac_state_t state_q;
   rbac_pkg::rbac_state_t state_d;
   logic keep_q;
   logic [2:0] align_q;
   logic collErr_q;
   logic [2:0] lastBits_q;
   logic [7:0] shift_q;
   logic [2:0] bitPos_q;
   logic [9:0] bitIndex_q;
   logic afterColl_q;
   logic integ_q;
   logic pending_q;
   logic [7:0] rdata_q;
   wire collision_index_valid;
   wire [6:0] first_collision_index;
   wire collSeen;
   wire fifoReady;
   wire takeBit;
   wire storedBit;
   wire [7:0] merged;
   wire byteDone;
   wire pushByte;
   wire wrCtrl;
   wire hitCtrl;
   wire hitColl;
   wire partial;
   wire [2:0] startAlign;

   // Bit position within a byte, wrapping at seven
   function automatic logic [2:0] rbac_next_pos(input logic [2:0] p);
      return (p == `RBAC_MAX_BIT) ? `RBAC_ZERO3 : 3'(p + `RBAC_ONE3);
   endfunction

   // Register decode
   assign hitCtrl = req.addr == `RBAC_ADDR_FRAMING;
   assign hitColl = req.addr == `RBAC_ADDR_FIRST_COLLISION_INDEX;
   assign wrCtrl = req.wr && hitCtrl;
   // Same offset for position and index, even if written at frame start
   assign startAlign = wrCtrl ? req.wdata[`RBAC_ALIGN_HI:`RBAC_ALIGN_LO] : align_q;

   // Receive datapath decode
   assign takeBit = bitStrobe && bitReady && state_q == rbac_pkg::RBAC_RECV;
   assign storedBit = (afterColl_q || rxBit.coll) && !keep_q ?
      1'b0 : rxBit.value;
   assign merged = shift_q | (8'(storedBit) << bitPos_q);
   assign byteDone = takeBit && bitPos_q == `RBAC_MAX_BIT;
   assign partial = bitPos_q != `RBAC_ZERO3;
   // Any staged byte holds the decoder back until the FIFO takes it
   assign bitReady = !pending_q;
   assign pushByte = pending_q;
   assign bitOriented = align_q != `RBAC_ZERO3;

   // Next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         rbac_pkg::RBAC_IDLE: begin
            if (frameStart) begin
               state_d = rbac_pkg::RBAC_RECV;
            end
         end
         rbac_pkg::RBAC_RECV: begin
            if (frameEnd) begin
               state_d = rbac_pkg::RBAC_FLUSH;
            end
         end
         rbac_pkg::RBAC_FLUSH: begin
            if (!pending_q) begin
               state_d = rbac_pkg::RBAC_IDLE;
            end
         end
         default: begin
            state_d = rbac_pkg::RBAC_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= rbac_pkg::RBAC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Control fields written by software
   always_ff @(posedge clock) begin
      if (rst) begin
         keep_q <= 1'(`RBAC_CTRL_RESET >> `RBAC_BIT_KEEP);
         align_q <= `RBAC_ZERO3;
         collErr_q <= 1'b0;
      end else if (wrCtrl) begin
         keep_q <= req.wdata[`RBAC_BIT_KEEP];
         align_q <= req.wdata[`RBAC_ALIGN_HI:`RBAC_ALIGN_LO];
         collErr_q <= req.wdata[`RBAC_BIT_COLLERR];
      end
   end

   // Last-bits field belongs to the decoder, not software
   always_ff @(posedge clock) begin
      if (rst || frameStart) begin
         lastBits_q <= `RBAC_ZERO3;
      end else if (frameEnd && state_q == rbac_pkg::RBAC_RECV &&
                   bitOriented) begin
         lastBits_q <= bitPos_q;
      end
   end

   // Assemble bytes; offset only for the first byte of a frame
   always_ff @(posedge clock) begin
      if (rst || frameStart) begin
         shift_q <= `RBAC_ZERO8;
         bitPos_q <= rst ? `RBAC_ZERO3 : startAlign;
         bitIndex_q <= rst ? 10'h000 : 10'(startAlign);
         afterColl_q <= 1'b0;
      end else if (takeBit) begin
         shift_q <= byteDone ? `RBAC_ZERO8 : merged;
         bitPos_q <= rbac_next_pos(bitPos_q);
         bitIndex_q <= 10'(bitIndex_q + 1'b1);
         afterColl_q <= afterColl_q || rxBit.coll;
      end else if (frameEnd && state_q == rbac_pkg::RBAC_RECV) begin
         shift_q <= `RBAC_ZERO8;
      end
   end

   // Byte staged for the FIFO, including a partial last byte
   always_ff @(posedge clock) begin
      if (rst) begin
         pending_q <= 1'b0;
         byteData <= `RBAC_ZERO8;
      end else if (byteDone || (frameEnd && state_q == rbac_pkg::RBAC_RECV
                                && partial)) begin
         pending_q <= 1'b1;
         byteData <= takeBit ? merged : shift_q;
      end else if (pending_q && fifoReady) begin
         pending_q <= 1'b0;
      end
   end

   // Integrity error stays set, reception goes on; set beats clear
   always_ff @(posedge clock) begin
      if (rst) begin
         integ_q <= 1'b0;
      end else if (takeBit && (parityErr || crcErr ||
                   (rxBit.coll && collErr_q))) begin
         integ_q <= 1'b1;
      end else if (frameStart) begin
         integ_q <= 1'b0;
      end
   end

   // Register read data from flip-flops
   always_ff @(posedge clock) begin
      if (rst) begin
         rdata_q <= `RBAC_ZERO8;
      end else if (req.rd && hitCtrl) begin
         rdata_q <= {keep_q, align_q, collErr_q, lastBits_q};
      end else if (req.rd && hitColl) begin
         rdata_q <= {collision_index_valid, first_collision_index};
      end else if (req.rd) begin
         rdata_q <= `RBAC_ZERO8;
      end
   end

   // Status outputs straight from their flip-flops
   assign rdata = rdata_q;
   assign integrityErr = integ_q;
   assign collisionSeen = collSeen;

   // First collision tracker, fed only with bits actually taken
   rbac_first_collision_index u_first_collision_index (
      .clock(clock),
      .rst(rst),
      .frameStart(frameStart),
      .bitStrobe(takeBit),
      .bitColl(rxBit.coll),
      .bitIndex(bitIndex_q),
      .seen(collSeen),
      .posValid(collision_index_valid),
      .position(first_collision_index)
   );

   // Byte buffer; its valid/ready reach the consumer, its data output is left open
   rbac_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .rst(rst),
      .inValid(pushByte),
      .inReady(fifoReady),
      .inData(byteData),
      .outValid(byteValid),
      .outReady(byteReady),
      .outData()
   );

   // Bits after a collision are forced low unless kept
   AST_ZERO_AFTER: assert property (@(posedge clock) disable iff (rst)
      takeBit && !keep_q && afterColl_q |-> storedBit == 1'b0)
      else $error("bit after collision not zeroed");

   // With the keep bit set the received value goes through as is
   AST_KEEP_VALUE: assert property (@(posedge clock) disable iff (rst)
      takeBit && keep_q |-> storedBit == rxBit.value)
      else $error("kept bit altered");

   // Collision reported as integrity error when enabled
   AST_COLL_INTEG: assert property (@(posedge clock) disable iff (rst)
      takeBit && rxBit.coll && collErr_q |=> integ_q)
      else $error("collision did not raise integrity error");

   // Set wins, so an error on the last bit is never lost
   AST_ERR_INTEG: assert property (@(posedge clock) disable iff (rst)
      takeBit && (parityErr || crcErr) |=> integ_q)
      else $error("integrity error not raised");

   // Error flag stays set until the next frame
   AST_INTEG_HOLD: assert property (@(posedge clock) disable iff (rst)
      integ_q && !frameStart |=> integ_q)
      else $error("integrity error dropped inside frame");

   // Last-bits cleared when a frame starts
   AST_LAST_CLEAR: assert property (@(posedge clock) disable iff (rst)
      frameStart |=> lastBits_q == 3'h0)
      else $error("last bits not cleared at start");

   // Bit-oriented end loads the position after the last bit
   AST_LAST_LOAD: assert property (@(posedge clock) disable iff (rst)
      frameEnd && state_q == rbac_pkg::RBAC_RECV && bitOriented &&
      !frameStart |=> lastBits_q == $past(bitPos_q))
      else $error("last bits not loaded at end");

   // Byte-oriented end leaves the field alone
   AST_BYTE_MODE: assert property (@(posedge clock)
      disable iff (rst)
      frameEnd && state_q == rbac_pkg::RBAC_RECV && !bitOriented &&
      !frameStart |=> lastBits_q == $past(lastBits_q))
      else $error("last bits changed in byte mode");

   // First bit lands at the programmed offset
   AST_ALIGN_FIRST: assert property (@(posedge clock) disable iff (rst)
      frameStart && !req.wr |=> bitPos_q == $past(align_q))
      else $error("first bit position not aligned");

   // Index starts at the offset so that it adds into the position
   AST_INDEX_START: assert property (@(posedge clock) disable iff (rst)
      frameStart |=> bitIndex_q == 10'($past(startAlign)))
      else $error("bit index not started at offset");

   // Position seven wraps to zero of the next byte
   AST_WRAP: assert property (@(posedge clock) disable iff (rst)
      takeBit && bitPos_q == 3'h7 && !frameStart |=> bitPos_q == 3'h0)
      else $error("position did not wrap to zero");

   // Inside a frame positions only step; the offset is never reapplied
   AST_STEP: assert property (@(posedge clock) disable iff (rst)
      takeBit && !frameStart |=> bitPos_q == 3'($past(bitPos_q) + 3'h1))
      else $error("bit position did not step by one");

   // Errors do not end reception
   AST_CONTINUE: assert property (@(posedge clock) disable iff (rst)
      state_q == rbac_pkg::RBAC_RECV && parityErr && !frameEnd |=>
      state_q == rbac_pkg::RBAC_RECV)
      else $error("reception stopped on integrity error");

   // Start clears the flag unless a collision is taken at that edge
   AST_COLL_CLEAR: assert property (@(posedge clock) disable iff (rst)
      frameStart && !(takeBit && rxBit.coll) |=> !collisionSeen)
      else $error("collision flag not cleared at start");

   // A taken collision bit is always recorded
   AST_COLL_SET: assert property (@(posedge clock) disable iff (rst)
      takeBit && rxBit.coll |=> collisionSeen)
      else $error("collision not recorded");

   // Staged byte waits unchanged while the FIFO is full
   AST_STAGE_HOLD: assert property (@(posedge clock) disable iff (rst)
      pending_q && !fifoReady |=>
      pending_q && byteData == $past(byteData))
      else $error("staged byte lost while FIFO full");

   // A partial final byte is staged when the frame ends
   AST_PARTIAL_PUSH: assert property (@(posedge clock) disable iff (rst)
      frameEnd && state_q == rbac_pkg::RBAC_RECV && partial && !takeBit
      |=> pending_q && byteData == $past(shift_q))
      else $error("partial final byte not staged");

   // Flush ends once the staged byte has left
   AST_FLUSH_DONE: assert property (@(posedge clock) disable iff (rst)
      state_q == rbac_pkg::RBAC_FLUSH && !pending_q |=>
      state_q == rbac_pkg::RBAC_IDLE)
      else $error("flush did not return to idle");
endmodule

/* File: rbac_regs.svh */
/*
 Register offsets, field positions and reset values of the receive bit
 framing block. Assumes inclusion by bare name from design files.
*/
`ifndef RBAC_REGS_SVH
`define RBAC_REGS_SVH
`define RBAC_ADDR_FRAMING 8'h0C
`define RBAC_ADDR_FIRST_COLLISION_INDEX 8'h0D
`define RBAC_BIT_KEEP 7
`define RBAC_ALIGN_HI 6
`define RBAC_ALIGN_LO 4
`define RBAC_BIT_COLLERR 3
`define RBAC_LAST_HI 2
`define RBAC_LAST_LO 0
`define RBAC_BIT_CPVALID 7
`define RBAC_CTRL_RESET 8'h80
`define RBAC_ZERO3 3'h0
`define RBAC_ZERO7 7'h00
`define RBAC_ZERO8 8'h00
`define RBAC_ONE3 3'h1
`define RBAC_MAX_BIT 3'h7
`define RBAC_COLL_LIMIT 7'h40
`define RBAC_FIFO_DEPTH 16
`endif

/* File: rbac_pkg.sv */
/*
 Types shared by the receive bit framing block.
 Assumes nothing of its surroundings.
*/
package rbac_pkg;
   // One received bit from the decoder
   typedef struct packed {
      logic value;
      logic coll;
   } rbac_bit_t;
   // Register bus request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rbac_req_t;
   // Receive sequence states
   typedef enum logic [2:0] {
      RBAC_IDLE = 3'b001,
      RBAC_RECV = 3'b010,
      RBAC_FLUSH = 3'b100
   } rbac_state_t;
endpackage

/* File: rbac_fifo.sv */
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/1ps
module rbac_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_q;
   logic [AW-1:0] rdPtr_q;
   logic [AW:0] count_q;
   wire doWrite;
   wire doRead;

   // Full only at DEPTH; the count is one bit wider than the pointers
   assign inReady = (count_q != (AW+1)'(DEPTH));
   assign outValid = (count_q != '0);
   assign doWrite = inValid && inReady;
   assign doRead = outValid && outReady;
   assign outData = mem[rdPtr_q];

   // Storage writes need no reset
   always_ff @(posedge clock) begin
      if (doWrite) begin
         mem[wrPtr_q] <= inData;
      end
   end

   // Pointer and occupancy
   always_ff @(posedge clock) begin
      if (rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         if (doWrite) begin
            wrPtr_q <= AW'(wrPtr_q + 1'b1);
         end
         if (doRead) begin
            rdPtr_q <= AW'(rdPtr_q + 1'b1);
         end
         count_q <= (AW+1)'(count_q + doWrite - doRead);
      end
   end

   AST_NO_OVERFLOW: assert property (@(posedge clock) disable iff (rst)
      count_q <= (AW+1)'(DEPTH))
      else $error("fifo count beyond depth");
endmodule

/* File: rbac_first_collision_index.sv */
/*
 Tracks the first collision of a frame and its position.
 Assumes the bit index counts stored data bit places from frame start.
*/
`timescale 1ns/1ps
`include "rbac_regs.svh"
module rbac_first_collision_index (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Frame control
   input wire logic frameStart,
   input wire logic bitStrobe,
   input wire logic bitColl,
   input wire logic [9:0] bitIndex,
   // Result
   output logic seen,
   output logic posValid,
   output logic [6:0] position
);
   logic seen_q;
   logic valid_q;
   logic [6:0] pos_q;
   wire firstColl;
   wire inRange;

   // Only the first collision of a frame is recorded
   assign firstColl = bitStrobe && bitColl && !seen_q;
   assign inRange = bitIndex < 10'(`RBAC_COLL_LIMIT);
   assign seen = seen_q;
   assign posValid = valid_q;
   assign position = pos_q;

   // Index already includes the alignment offset; a collision beats start
   always_ff @(posedge clock) begin
      if (rst) begin
         seen_q <= 1'b0;
         valid_q <= 1'b0;
         pos_q <= `RBAC_ZERO7;
      end else if (firstColl) begin
         seen_q <= 1'b1;
         valid_q <= inRange;
         pos_q <= inRange ? bitIndex[6:0] : `RBAC_ZERO7;
      end else if (frameStart) begin
         seen_q <= 1'b0;
         valid_q <= 1'b0;
         pos_q <= `RBAC_ZERO7;
      end
   end

   AST_VALID_RANGE: assert property (@(posedge clock) disable iff (rst)
      firstColl && !frameStart |=> posValid == ($past(bitIndex) < 10'd64) &&
      (posValid -> position == $past(bitIndex[6:0])))
      else $error("collision position mismatch");
endmodule

/* File: rbac_card_model.sv */
/*
 Decoder-side model of the far party: sends framed bits with collision
 and parity marks. Assumes the framer takes a bit on a rising edge
 while bitReady is high.
*/
`timescale 1ns/1ps
module rbac_card_model (
   // Clock
   input wire logic clock,
   // Framer handshake
   input wire logic bitReady,
   // Decoder outputs
   output logic frameStart,
   output logic frameEnd,
   output logic bitStrobe,
   output rbac_pkg::rbac_bit_t rxBit,
   output logic parityErr,
   output logic crcErr
);
   // Quiet lines at time zero
   initial begin
      frameStart = 1'b0;
      frameEnd = 1'b0;
      bitStrobe = 1'b0;
      rxBit = 2'h0;
      parityErr = 1'b0;
      crcErr = 1'b0;
   end

   // One frame; a bit is held until the edge that takes it
   // A par equal to n flags a CRC fault with the final bit
   task automatic send(input int n, input logic [143:0] bits,
         input int coll, input int par);
      int i;
      @(posedge clock);
      frameStart <= 1'b1;
      @(posedge clock);
      frameStart <= 1'b0;
      for (i = 0; i < n; i++) begin
         bitStrobe <= 1'b1;
         rxBit <= '{value: bits[i], coll: (i == coll)};
         parityErr <= (i == par);
         crcErr <= (par == n) && (i == n - 1);
         do @(negedge clock); while (bitReady !== 1'b1);
         @(posedge clock);
      end
      // Released line shows the inverse, not a stale bit
      bitStrobe <= 1'b0;
      rxBit <= '{value: ~bits[n-1], coll: 1'b0};
      parityErr <= 1'b0;
      crcErr <= 1'b0;
      frameEnd <= 1'b1;
      @(posedge clock);
      frameEnd <= 1'b0;
   endtask
endmodule

/* File: test_rx_bit_align_collision.sv */
/*
 Self-checking bench of the receive bit framer.
 Assumes the framer package and the decoder-side model file.
*/
`timescale 1ns/1ps
module test_rx_bit_align_collision;
   logic clock, rst, bitReady, byteValid, byteReady, rdyPrev;
   logic integrityErr, collisionSeen, bitOriented;
   logic frameStart, frameEnd, bitStrobe, parityErr, crcErr;
   logic [7:0] rdata, byteData;
   logic [7:0] got[$];
   rbac_pkg::rbac_req_t req;
   rbac_pkg::rbac_bit_t rxBit;
   int fail_count = 0;
   int n_checks = 0;

   rbac_framer #(.FIFO_DEPTH(16)) uut (.clock(clock), .rst(rst),
      .req(req), .rdata(rdata), .frameStart(frameStart),
      .frameEnd(frameEnd), .bitStrobe(bitStrobe), .rxBit(rxBit),
      .parityErr(parityErr), .crcErr(crcErr), .bitReady(bitReady),
      .byteValid(byteValid), .byteReady(byteReady),
      .byteData(byteData), .integrityErr(integrityErr),
      .collisionSeen(collisionSeen), .bitOriented(bitOriented));
   rbac_card_model card (.clock(clock), .bitReady(bitReady),
      .frameStart(frameStart), .frameEnd(frameEnd),
      .bitStrobe(bitStrobe), .rxBit(rxBit), .parityErr(parityErr),
      .crcErr(crcErr));

   // 20 MHz clock
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // Staged byte is caught once, as bitReady falls
   initial rdyPrev = 1'b1;
   always @(negedge clock) begin
      if (bitReady === 1'b0 && rdyPrev === 1'b1) got.push_back(byteData);
      rdyPrev = bitReady;
   end

   // Run ends here, normally or on a hang
   task conclude;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task cmp(input string name, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, e, g);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clock);
      req.wr <= 1'b0;
   endtask

   // Read and compare; data is valid the cycle after the request
   task rdc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clock);
      req.rd <= 1'b0;
      @(negedge clock);
      cmp($sformatf("reg %h", a), e, rdata);
   endtask

   // Wait for the byte path to empty, bounded
   task settle;
      int k;
      repeat (3) @(negedge clock);
      for (k = 0; k < 200 && byteValid !== 1'b0; k++) @(negedge clock);
   endtask

   task t_reset;
      rdc(8'h0C, 8'h80);
      rdc(8'h0D, 8'h00);
      wr(8'h0D, 8'hFF);
      rdc(8'h0D, 8'h00);
      rdc(8'h20, 8'h00);
      cmp("bitOriented", 8'h00, {7'h00, bitOriented});
   endtask

   task t_bytes;
      got.delete();
      card.send(16, 144'h3CA5, -1, 16);
      settle();
      cmp("integ", 8'h01, {7'h00, integrityErr});
      cmp("byte0", 8'hA5, got[0]);
      cmp("byte1", 8'h3C, got[1]);
      rdc(8'h0C, 8'h80);
   endtask

   task t_align7;
      wr(8'h0C, 8'hF0);
      got.delete();
      card.send(10, 144'h2B5, 3, -1);
      settle();
      cmp("bitOriented", 8'h01, {7'h00, bitOriented});
      cmp("byte0", 8'h80, got[0] & 8'h80);
      cmp("byte1", 8'h5A, got[1]);
      cmp("byte2", 8'h01, got[2] & 8'h01);
      rdc(8'h0C, 8'hF1);
      rdc(8'h0D, 8'h8A);
      cmp("collSeen", 8'h01, {7'h00, collisionSeen});
      cmp("integ", 8'h00, {7'h00, integrityErr});
   endtask

   task t_align4;
      wr(8'h0C, 8'hC0);
      fork
         card.send(11, 144'h5A5, 3, -1);
         begin
            repeat (4) @(posedge clock);
            rdc(8'h0C, 8'hC0);
         end
      join
      settle();
      rdc(8'h0C, 8'hC7);
      rdc(8'h0D, 8'h87);
   endtask

   // Zeroing after a collision, which also flags integrity
   task t_zero;
      wr(8'h0C, 8'h08);
      got.delete();
      card.send(16, '1, 5, -1);
      settle();
      cmp("byte0", 8'h1F, got[0]);
      cmp("byte1", 8'h00, got[1]);
      cmp("integ", 8'h01, {7'h00, integrityErr});
      rdc(8'h0D, 8'h85);
   endtask

   task t_far;
      wr(8'h0C, 8'h80);
      got.delete();
      card.send(72, '1, 64, 2);
      settle();
      cmp("count", 8'h09, 8'(got.size()));
      cmp("integ", 8'h01, {7'h00, integrityErr});
      rdc(8'h0D, 8'h00);
      fork
         card.send(64, '1, 63, -1);
         begin
            repeat (4) @(negedge clock);
            cmp("collSeen", 8'h00, {7'h00, collisionSeen});
         end
      join
      settle();
      rdc(8'h0D, 8'hBF);
   endtask

   // Full buffer stalls the decoder, then drains
   task t_stall;
      @(posedge clock);
      byteReady <= 1'b0;
      got.delete();
      fork
         card.send(144, '1, -1, -1);
         begin
            repeat (170) @(negedge clock);
            cmp("bitReady", 8'h00, {7'h00, bitReady});
            cmp("byteValid", 8'h01, {7'h00, byteValid});
            @(posedge clock);
            byteReady <= 1'b1;
         end
      join
      settle();
      cmp("drained", 8'h00, {7'h00, byteValid});
      cmp("count", 8'h12, 8'(got.size()));
   endtask

   // Main sequence after a three-cycle reset
   initial begin
      rst = 1'b1;
      req = '0;
      byteReady = 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      t_reset();
      t_bytes();
      t_align7();
      t_align4();
      t_zero();
      t_far();
      t_stall();
      conclude();
   end

   // Watchdog, far beyond the expected run
   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      conclude();
   end
endmodule
